// ### wds_regs.svh
// timing constants and field codes for the window watchdog supervisor
// assumes a 50 MHz ref_clk; included by bare name from the package, select evaluator and watchdog files
// Functional notes
// - watchdog is off while the disable input is grounded, on otherwise
// - kick input ignored while reset low, fault low, or watchdog disabled
// - timeout pulls fault output low, only while reset output is high
// - fault output held low for exactly the reset hold delay, then released
// - fault output released (not driven) whenever reset output is low
// - manual reset low asserts reset; held low reset delay after release
// - upper timeout chosen from select pin: capacitor, pull-up or open
// - select pin evaluated over a 381 us period before timeout applies
`ifndef WDS_REGS_SVH
`define WDS_REGS_SVH

// ----------------------------------------
// clock and times
// ----------------------------------------
`define WDS_CLK_KHZ        50000
`define WDS_RST_HOLD_MS    200
`define WDS_RST_HOLD_CYC   ((`WDS_RST_HOLD_MS * `WDS_CLK_KHZ))
`define WDS_EVAL_US        381
`define WDS_EVAL_CYC       ((`WDS_EVAL_US * `WDS_CLK_KHZ) / 1000)

// ----------------------------------------
// window defaults and widths
// ----------------------------------------
`define WDS_UPPER_CAP_CYC  1000
`define WDS_UPPER_PU_CYC   2000
`define WDS_UPPER_NC_CYC   4000
`define WDS_LOWER_SHIFT    3
`define WDS_CNT_W          24
`define WDS_SEL_W          2

`endif

// ### wds_pkg.sv
// types shared by the window watchdog supervisor modules
// assumes wds_regs.svh supplies the widths
`include "wds_regs.svh"
package wds_pkg;

  // select pin strapping as seen by the pin sensor
  typedef enum logic [`WDS_SEL_W-1:0] {
    WDS_SEL_CAP    = 2'h0,
    WDS_SEL_PULLUP = 2'h1,
    WDS_SEL_OPEN   = 2'h2,
    WDS_SEL_RSVD   = 2'h3
  } wds_sel_t;

  // watchdog sequencer, one-hot
  typedef enum logic [2:0] {
    WDS_ST_INIT  = 3'h1,
    WDS_ST_RUN   = 3'h2,
    WDS_ST_FAULT = 3'h4
  } wds_state_t;

endpackage

// ### wds_sel_if.sv
// carrier between the select evaluator and the watchdog core
// assumes one clock domain
`timescale 1ns/1ns
interface wds_sel_if;
  import wds_pkg::*;
  logic     done;
  wds_sel_t code;
  modport prov (output done, output code);
  modport cons (input done, input code);
endinterface

// ### wds_sel_eval.sv
// evaluates the timeout select strapping once after reset release
// assumes the strap is stable during the evaluation period
`timescale 1ns/1ns
`include "wds_regs.svh"
module wds_sel_eval
  import wds_pkg::*;
#(
  parameter int unsigned EVAL_CYC = `WDS_EVAL_CYC
)
(
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 arst_n,
  // strap
  input  wire logic [`WDS_SEL_W-1:0] timeout_select_pin,
  // result
  wds_sel_if.prov                   sel
);

  logic [`WDS_CNT_W-1:0] eval_cnt_reg;
  logic                  done_reg;
  wds_sel_t              code_reg;
  logic                  eval_last;

  if (EVAL_CYC < 1 || EVAL_CYC >= (1 << `WDS_CNT_W))
  begin : g_chk
    $error("evaluation count out of range");
  end

  assign eval_last = (eval_cnt_reg == `WDS_CNT_W'(EVAL_CYC - 1));

  // strap caught by a clocked process after release, never by the reset itself
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      eval_cnt_reg <= '0;
      done_reg     <= 1'b0;
      code_reg     <= WDS_SEL_OPEN;
    end
    else if (!done_reg)
    begin
      eval_cnt_reg <= eval_cnt_reg + 1'b1;
      if (eval_last)
      begin
        done_reg <= 1'b1;
        code_reg <= wds_sel_t'(timeout_select_pin);
      end
    end
  end

  assign sel.done = done_reg;
  assign sel.code = code_reg;

  a_eval_length : assert property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(done_reg) |-> $past(eval_cnt_reg) == `WDS_CNT_W'(EVAL_CYC - 1))
    else $error("select evaluation ended at the wrong count");

endmodule

// ### wds_watchdog.sv
// window watchdog with reset generator and open-drain fault and reset pins
// assumes supply_ok comes from an external undervoltage comparator, synchronous
`timescale 1ns/1ns
`include "wds_regs.svh"
module wds_watchdog
  import wds_pkg::*;
#(
  parameter int unsigned RST_HOLD_CYC  = `WDS_RST_HOLD_CYC,
  parameter int unsigned EVAL_CYC      = `WDS_EVAL_CYC,
  parameter int unsigned UPPER_CAP_CYC = `WDS_UPPER_CAP_CYC,
  parameter int unsigned UPPER_PU_CYC  = `WDS_UPPER_PU_CYC,
  parameter int unsigned UPPER_NC_CYC  = `WDS_UPPER_NC_CYC
)
(
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  arst_n,
  // host side inputs
  input  wire logic                  watchdog_disable_input,
  input  wire logic                  watchdog_kick_input,
  input  wire logic                  manual_reset_input,
  input  wire logic                  supply_ok,
  input  wire logic [`WDS_SEL_W-1:0] timeout_select_pin,
  // open-drain reset output, low when driven
  input  wire logic                  reset_out_i,
  output logic                       reset_out_o,
  output logic                       reset_out_oe,
  // open-drain watchdog fault output, low when driven
  input  wire logic                  watchdog_fault_output_i,
  output logic                       watchdog_fault_output_o,
  output logic                       watchdog_fault_output_oe
);

  // ----------------------------------------
  // checks and helpers
  // ----------------------------------------
  localparam int unsigned CNT_MAX = (1 << `WDS_CNT_W) - 1;

  // reset must stand for two cycles at least, so a manual reset is always seen
  if (RST_HOLD_CYC < 2 || RST_HOLD_CYC > CNT_MAX || UPPER_CAP_CYC < 2
      || UPPER_PU_CYC < 2 || UPPER_NC_CYC < 2 || UPPER_CAP_CYC > CNT_MAX
      || UPPER_PU_CYC > CNT_MAX || UPPER_NC_CYC > CNT_MAX)
  begin : g_chk
    $error("watchdog timing parameters out of range");
  end

  // lower bound is a fixed fraction of the upper bound
  function automatic logic [`WDS_CNT_W-1:0] lower_of(input logic [`WDS_CNT_W-1:0] up);
    lower_of = up >> `WDS_LOWER_SHIFT;
  endfunction

  wds_sel_if sel_bus ();

  wds_sel_eval #(
    .EVAL_CYC           (EVAL_CYC)
  ) u_sel (
    .ref_clk            (ref_clk),
    .arst_n             (arst_n),
    .timeout_select_pin (timeout_select_pin),
    .sel                (sel_bus.prov)
  );

  // ----------------------------------------
  // reset generator
  // ----------------------------------------
  logic [`WDS_CNT_W-1:0] rst_cnt_reg;
  logic                  rst_low_reg;
  logic                  rst_cause;
  logic                  rst_done;

  assign rst_cause = !manual_reset_input || !supply_ok;
  assign rst_done  = (rst_cnt_reg == `WDS_CNT_W'(RST_HOLD_CYC - 1));

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_low_reg <= 1'b1;
      rst_cnt_reg <= '0;
    end
    else if (rst_cause)
    begin
      rst_low_reg <= 1'b1;
      rst_cnt_reg <= '0;
    end
    else if (rst_low_reg)
    begin
      rst_low_reg <= !rst_done;
      rst_cnt_reg <= rst_done ? '0 : rst_cnt_reg + 1'b1;
    end
  end

  assign reset_out_o  = 1'b0;
  assign reset_out_oe = rst_low_reg;

  // ----------------------------------------
  // window decode
  // ----------------------------------------
  wds_state_t            state_reg;
  wds_state_t            state_next;
  logic [`WDS_CNT_W-1:0] win_cnt_reg;
  logic [`WDS_CNT_W-1:0] win_cnt_next;
  logic [`WDS_CNT_W-1:0] flt_cnt_reg;
  logic [`WDS_CNT_W-1:0] flt_cnt_next;
  logic                  kick_prev_reg;
  logic [`WDS_CNT_W-1:0] upper_cyc;
  logic [`WDS_CNT_W-1:0] lower_cyc;
  logic                  wd_enabled;
  logic                  kick_fall;
  logic                  kick_early;
  logic                  win_expired;
  logic                  kick_ok;
  logic                  fault_start;
  logic                  fault_done;

  assign upper_cyc = (sel_bus.code == WDS_SEL_CAP)    ? `WDS_CNT_W'(UPPER_CAP_CYC) :
                     (sel_bus.code == WDS_SEL_PULLUP) ? `WDS_CNT_W'(UPPER_PU_CYC)  :
                                                        `WDS_CNT_W'(UPPER_NC_CYC);
  assign lower_cyc   = lower_of(upper_cyc);
  assign wd_enabled  = watchdog_disable_input;
  // edge only counts while running, enabled and reset released
  assign kick_fall   = kick_prev_reg && !watchdog_kick_input && wd_enabled
                       && !rst_low_reg && (state_reg == WDS_ST_RUN);
  assign kick_early  = kick_fall && (win_cnt_reg < lower_cyc);
  assign kick_ok     = kick_fall && !kick_early;
  assign win_expired = wd_enabled && !rst_low_reg && (state_reg == WDS_ST_RUN)
                       && (win_cnt_reg >= upper_cyc - 1'b1);
  // an accepted kick in the last window cycle wins over the expiry
  assign fault_start = (kick_early || (win_expired && !kick_ok)) && !rst_low_reg;
  assign fault_done  = (flt_cnt_reg == `WDS_CNT_W'(RST_HOLD_CYC - 1));

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb
  begin
    state_next   = state_reg;
    win_cnt_next = win_cnt_reg;
    flt_cnt_next = flt_cnt_reg;
    unique case (state_reg)
      WDS_ST_INIT:
      begin
        win_cnt_next = '0;
        if (sel_bus.done)
          state_next = WDS_ST_RUN;
      end
      WDS_ST_RUN:
      begin
        if (rst_low_reg || !wd_enabled || kick_ok)
          win_cnt_next = '0;
        else if (fault_start)
        begin
          state_next   = WDS_ST_FAULT;
          flt_cnt_next = '0;
          win_cnt_next = '0;
        end
        else
          win_cnt_next = win_cnt_reg + 1'b1;
      end
      WDS_ST_FAULT:
      begin
        // a system reset ends the fault pulse; the pin is released anyway
        if (rst_low_reg || fault_done)
        begin
          state_next   = WDS_ST_RUN;
          flt_cnt_next = '0;
        end
        else
          flt_cnt_next = flt_cnt_reg + 1'b1;
      end
      default:
      begin
        state_next   = WDS_ST_INIT;
        win_cnt_next = '0;
        flt_cnt_next = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg     <= WDS_ST_INIT;
      win_cnt_reg   <= '0;
      flt_cnt_reg   <= '0;
      kick_prev_reg <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      win_cnt_reg   <= win_cnt_next;
      flt_cnt_reg   <= flt_cnt_next;
      kick_prev_reg <= watchdog_kick_input;
    end
  end

  // gated by reset level so the pin floats in the same cycle reset goes low
  assign watchdog_fault_output_o  = 1'b0;
  assign watchdog_fault_output_oe = (state_reg == WDS_ST_FAULT) && !rst_low_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_fault_entry;
    fault_start ##1 (state_reg == WDS_ST_FAULT);
  endsequence

  sequence s_window_restart;
    kick_ok ##1 (win_cnt_reg == '0);
  endsequence

  a_disable_no_fault : assert property (@(posedge ref_clk) disable iff (!arst_n)
    !watchdog_disable_input |-> !fault_start)
    else $error("fault raised while watchdog disabled");

  a_kick_ignored : assert property (@(posedge ref_clk) disable iff (!arst_n)
    (rst_low_reg || watchdog_fault_output_oe) |-> !kick_fall)
    else $error("kick accepted while reset or fault low");

  a_fault_needs_reset_high : assert property (@(posedge ref_clk) disable iff (!arst_n)
    watchdog_fault_output_oe |-> !reset_out_oe)
    else $error("fault driven while reset low");

  a_fault_entry : assert property (@(posedge ref_clk) disable iff (!arst_n)
    fault_start |-> s_fault_entry)
    else $error("timeout did not enter fault");

  a_fault_length : assert property (@(posedge ref_clk) disable iff (!arst_n)
    ($fell(watchdog_fault_output_oe) && !reset_out_oe)
      |-> $past(flt_cnt_reg) == `WDS_CNT_W'(RST_HOLD_CYC - 1))
    else $error("fault pulse has wrong length");

  a_reset_releases : assert property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(rst_low_reg) |-> !watchdog_fault_output_oe ##1 (state_reg != WDS_ST_FAULT))
    else $error("fault not released on reset");

  a_manual_reset : assert property (@(posedge ref_clk) disable iff (!arst_n)
    !manual_reset_input |=> reset_out_oe [*2])
    else $error("manual reset did not hold reset low");

  a_reset_hold : assert property (@(posedge ref_clk) disable iff (!arst_n)
    $fell(rst_low_reg) |-> $past(rst_cnt_reg) == `WDS_CNT_W'(RST_HOLD_CYC - 1)
      && $past(!rst_cause))
    else $error("reset released at wrong time");

  a_early_kick : assert property (@(posedge ref_clk) disable iff (!arst_n)
    (kick_fall && win_cnt_reg < lower_cyc) |-> s_fault_entry)
    else $error("early kick not treated as timeout");

  a_window_restart : assert property (@(posedge ref_clk) disable iff (!arst_n)
    kick_ok |-> s_window_restart)
    else $error("window not restarted by kick");

  a_wait_select : assert property (@(posedge ref_clk) disable iff (!arst_n)
    !sel_bus.done |=> (state_reg == WDS_ST_INIT) || $past(sel_bus.done))
    else $error("watchdog ran before select evaluation");

endmodule

// ### wds_host_model.sv
// host model that services the watchdog kick line with a set period
// assumes the bench changes run and period just after a rising edge
`timescale 1ns/1ns
module wds_host_model (
  // clock
  input  wire logic       ref_clk,
  // control from the bench
  input  wire logic       run,
  input  wire logic [7:0] period,
  // kick line to the device
  output logic            kick
);
  int cnt = 0;
  initial kick = 1'b1;
  // the line is always driven, never floated, even while not kicking
  always @(posedge ref_clk)
  begin
    #1;
    if (!run)
    begin
      kick = 1'b1;
      cnt  = 0;
    end
    else if (cnt >= int'(period) - 1)
    begin
      kick = 1'b0;
      cnt  = 0;
    end
    else
    begin
      kick = 1'b1;
      cnt  = cnt + 1;
    end
  end
endmodule

// ### wds_watchdog_test.sv
// self-checking bench for the window watchdog with a kicking host model
// assumes shortened counts; open-drain pins resolved here with pull-ups
`timescale 1ns/1ns
module wds_watchdog_test;
  import wds_pkg::*;
  // ----------------------------------------
  // counts and signals
  // ----------------------------------------
  localparam int HOLD = 20;
  localparam int UCAP = 64;
  localparam int UPU  = 96;
  localparam int UNC  = 128;
  logic       ref_clk                = 1'b0;
  logic       arst_n                 = 1'b0;
  logic       watchdog_disable_input = 1'b1;
  logic       manual_reset_input     = 1'b1;
  logic       supply_ok              = 1'b1;
  logic [1:0] timeout_select_pin     = 2'h0;
  logic       run                    = 1'b0;
  logic [7:0] period                 = 8'h20;
  logic       watchdog_kick_input;
  logic       reset_out_o;
  logic       reset_out_oe;
  logic       watchdog_fault_output_o;
  logic       watchdog_fault_output_oe;
  int         bad_count              = 0;
  int         samples_checked        = 0;
  // both pins have pull-ups, so a released pin reads high
  wire reset_wire = reset_out_oe ? reset_out_o : 1'b1;
  wire fault_wire = watchdog_fault_output_oe ? watchdog_fault_output_o : 1'b1;
  wire [1:0] pins = {reset_out_oe, watchdog_fault_output_oe};

  always #10 ref_clk = ~ref_clk;

  wds_watchdog #(.RST_HOLD_CYC(HOLD), .EVAL_CYC(8), .UPPER_CAP_CYC(UCAP),
    .UPPER_PU_CYC(UPU), .UPPER_NC_CYC(UNC)) uut (
    .ref_clk                 (ref_clk),
    .arst_n                  (arst_n),
    .watchdog_disable_input  (watchdog_disable_input),
    .watchdog_kick_input     (watchdog_kick_input),
    .manual_reset_input      (manual_reset_input),
    .supply_ok               (supply_ok),
    .timeout_select_pin      (timeout_select_pin),
    .reset_out_i             (reset_wire),
    .reset_out_o             (reset_out_o),
    .reset_out_oe            (reset_out_oe),
    .watchdog_fault_output_i (fault_wire),
    .watchdog_fault_output_o (watchdog_fault_output_o),
    .watchdog_fault_output_oe(watchdog_fault_output_oe)
  );

  wds_host_model host (
    .ref_clk(ref_clk),
    .run    (run),
    .period (period),
    .kick   (watchdog_kick_input)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input bit ok, input string msg);
    samples_checked++;
    if (!ok)
    begin
      bad_count++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask

  // bounded wait for an output enable to reach a level
  task automatic wait_lvl(input int sel, input logic val, input int lim, output int n);
    n = 0;
    while (pins[sel] !== val && n < lim)
    begin
      cyc(1);
      n++;
    end
  endtask

  task automatic do_reset(input logic [1:0] code);
    int n;
    arst_n = 1'b0;
    timeout_select_pin = code;
    cyc(3);
    chk(reset_out_oe === 1'b1 && watchdog_fault_output_oe === 1'b0, "pins in reset");
    arst_n = 1'b1;
    wait_lvl(1, 1'b0, 4 * HOLD, n);
    chk(n >= HOLD - 1 && n <= HOLD + 2, "reset hold length");
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_select;
    int n;
    int up [4] = '{UCAP, UPU, UNC, UNC};
    for (int i = 0; i < 4; i++)
    begin
      run = 1'b0;
      do_reset(i[1:0]);
      wait_lvl(0, 1'b1, 2 * UNC, n);
      chk(n >= up[i] - 2 && n <= up[i] + 2, "upper bound");
      chk(reset_wire === 1'b1 && fault_wire === 1'b0, "fault pin level");
      wait_lvl(0, 1'b0, 4 * HOLD, n);
      chk(n == HOLD, "fault length");
    end
    $display("test select done");
  endtask

  task automatic t_kick;
    int n;
    int per [3] = '{10, 32, 58};
    for (int i = 0; i < 3; i++)
    begin
      run = 1'b0;
      do_reset(2'h0);
      period = per[i][7:0];
      run = 1'b1;
      wait_lvl(0, 1'b1, 400, n);
      chk(n == 400, "fault with timely kicks");
    end
    run = 1'b0;
    $display("test kick done");
  endtask

  task automatic t_early;
    int n;
    do_reset(2'h0);
    period = 8'h04;
    run = 1'b1;
    wait_lvl(0, 1'b1, 20, n);
    chk(n < 20, "early kick missed");
    // kicks keep coming during the pulse and must not change it
    wait_lvl(0, 1'b0, 4 * HOLD, n);
    chk(n == HOLD, "fault length while kicking");
    run = 1'b0;
    $display("test early done");
  endtask

  task automatic t_disable;
    int n;
    do_reset(2'h0);
    watchdog_disable_input = 1'b0;
    period = 8'h03;
    run = 1'b1;
    wait_lvl(0, 1'b1, 300, n);
    chk(n == 300, "fault while disabled and kicked");
    run = 1'b0;
    wait_lvl(0, 1'b1, 200, n);
    chk(n == 200, "fault while disabled");
    watchdog_disable_input = 1'b1;
    wait_lvl(0, 1'b1, 2 * UCAP, n);
    chk(n >= UCAP - 2 && n <= UCAP + 2, "window after enable");
    wait_lvl(0, 1'b0, 4 * HOLD, n);
    chk(n == HOLD, "fault length after enable");
    $display("test disable done");
  endtask

  task automatic t_manual;
    int n;
    do_reset(2'h0);
    wait_lvl(0, 1'b1, 2 * UCAP, n);
    cyc(5);
    manual_reset_input = 1'b0;
    cyc(2);
    chk(fault_wire === 1'b1 && reset_wire === 1'b0, "fault not released");
    cyc(5);
    manual_reset_input = 1'b1;
    wait_lvl(1, 1'b0, 4 * HOLD, n);
    chk(n >= HOLD - 1 && n <= HOLD + 2, "hold after manual reset");
    // a supply dip is the other reset cause and restarts the same hold
    supply_ok = 1'b0;
    cyc(3);
    chk(reset_wire === 1'b0 && fault_wire === 1'b1, "reset on supply loss");
    supply_ok = 1'b1;
    wait_lvl(1, 1'b0, 4 * HOLD, n);
    chk(n == HOLD, "hold after supply return");
    $display("test manual done");
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    int n;
    cyc(16);
    arst_n = 1'b1;
    // let the first release finish before the scenarios reset again
    wait_lvl(1, 1'b0, 4 * HOLD, n);
    chk(n == HOLD, "first reset hold");
    t_select;
    t_kick;
    t_early;
    t_disable;
    t_manual;
    give_verdict;
  end

  // the whole run needs about 2700 cycles; this is far beyond it
  initial
  begin
    #400000;
    bad_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    give_verdict;
  end
endmodule
